/* inc/sar_mem_cfg.svh */
// constants for the external memory layout and access sequencer
// assumes a 16-bit processor port with word offsets as printed
`ifndef SAR_MEM_CFG_SVH
`define SAR_MEM_CFG_SVH
`define REG_SEG_BASE         16'h2040
`define REG_TX_FIFO_BASE     16'h2050
`define REG_REASSEMBLY_CONTROL_BASE      16'h4000
`define REG_RX_FIFO_BASE     16'h4020
`define SEG_BASE_W           5
`define FIFO_BASE_W          12
`define REASSEMBLY_CONTROL_BASE_W        3
`define REG_RESET            16'h0000
`define CELL_CTRL_READS      5'h03
`define CELL_MAX_SELECTS     5'h18
`define CELL_SELECT_OFFSET   8'h0C
`define SCHED_FRAME_READS    5'h08
`define CB_CTRL_READS        5'h01
`define CB_HALF_READS        5'h04
`define WORD_STRIDE          8'h04
`define BYTE_STRIDE          8'h01
`define RX_BUF_MIN_LOG2      6
`define RX_BUF_MAX_SIZE_CODE 3'h4
`define FIFO_SLOT_LOG2       6
`endif

/* inc/sar_mem_pkg.sv */
// types shared by the memory layout block
// assumes sar_mem_cfg.svh is compiled alongside
`default_nettype none
package sar_mem_pkg;
  typedef enum logic [1:0] {JOB_CELL, JOB_SCHED, JOB_CB_CTRL, JOB_CB_DATA} job_kind_t;
  typedef struct packed {
    job_kind_t   kind;
    logic [20:0] base;
    logic [4:0]  count;
  } job_t;
  typedef enum logic [2:0] {FORM_RX_BUF, FORM_REASSEMBLY_CONTROL, FORM_TX_FIFO, FORM_RX_FIFO,
                            FORM_MEMCTL} form_kind_t;
  typedef struct packed {
    form_kind_t  kind;
    logic [20:0] ptr;
    logic [2:0]  size_code;
    logic [12:0] offset;
  } form_req_t;
  typedef struct packed {
    logic [20:0] addr;
    logic        we;
    logic        half;
  } mem_acc_t;
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_PRE, SEQ_WR, SEQ_POST} seq_state_t;
  typedef struct packed {
    seq_state_t  st;
    job_kind_t   kind;
    logic [20:0] base;
    logic [4:0]  left;
    logic [4:0]  post_n;
    logic [7:0]  off;
    mem_acc_t    acc;
    logic [15:0] seg_base;
    logic [15:0] tx_fifo;
    logic [15:0] reassembly_control;
    logic [15:0] rx_fifo;
    logic [15:0] rdata;
    logic [20:0] form_addr;
    logic        form_vld;
  } state_t;
endpackage
`default_nettype wire

/* core/sar_external_memory_layout.sv */
// external memory address former and transmit access sequencer
// assumes software keeps every structure aligned; memory acks one access at a time
`include "sar_mem_cfg.svh"
`default_nettype none
module sar_external_memory_layout (
  input  wire logic                  sys_clk_in,
  input  wire logic                  rst_in,
  input  wire logic [15:0]           cpu_addr_in,
  input  wire logic [15:0]           cpu_wdata_in,
  input  wire logic                  cpu_wr_in,
  input  wire logic                  cpu_rd_in,
  output logic      [15:0]           cpu_rdata_out,
  input  wire logic                  job_valid_in,
  input  wire sar_mem_pkg::job_t     job_in,
  output logic                       job_ready_out,
  output logic                       mem_req_out,
  output sar_mem_pkg::mem_acc_t      mem_acc_out,
  input  wire logic                  mem_ack_in,
  input  wire logic                  form_valid_in,
  input  wire sar_mem_pkg::form_req_t form_in,
  output logic                       form_valid_out,
  output logic      [20:0]           form_addr_out
);
  import sar_mem_pkg::*;

  state_t      s_q;
  state_t      s_d;
  logic [20:0] rxbuf_addr;
  logic [3:0]  buf_log2;
  logic        job_take;

  // size code 0..4 selects 64..1024; larger codes clamp to 1024
  always_comb begin
    if (form_in.size_code > `RX_BUF_MAX_SIZE_CODE) begin
      buf_log2 = 4'(`RX_BUF_MIN_LOG2) + 4'(`RX_BUF_MAX_SIZE_CODE);
    end else begin
      buf_log2 = 4'(`RX_BUF_MIN_LOG2) + {1'b0, form_in.size_code};
    end
  end

  // per-bit pick of entry or offset
  genvar gi;
  generate
    for (gi = 0; gi < 21; gi++) begin : g_rxbuf
      if (gi < 13) begin : g_low
        assign rxbuf_addr[gi] = (4'(gi) < buf_log2) ? form_in.offset[gi] : form_in.ptr[gi];
      end else begin : g_high
        assign rxbuf_addr[gi] = form_in.ptr[gi];
      end
    end
  endgenerate

  // low byte wraps so a structure never spills past its block
  function automatic mem_acc_t make_acc(input state_t s);
    mem_acc_t a;
    a.addr = {s.base[20:8], 8'(s.base[7:0] + s.off)};
    a.we   = (s.st == SEQ_WR);
    a.half = (s.st == SEQ_POST) && (s.kind == JOB_CB_DATA);
    return a;
  endfunction

  assign job_ready_out = (s_q.st == SEQ_IDLE);
  assign job_take      = job_valid_in && job_ready_out;
  assign mem_req_out   = (s_q.st != SEQ_IDLE);
  assign mem_acc_out   = s_q.acc;
  assign cpu_rdata_out = s_q.rdata;
  assign form_valid_out = s_q.form_vld;
  assign form_addr_out  = s_q.form_addr;

  always_comb begin
    s_d          = s_q;
    s_d.form_vld = 1'b0;
    // register writes; unmapped offsets are ignored
    if (cpu_wr_in) begin
      unique case (cpu_addr_in)
        `REG_SEG_BASE:     s_d.seg_base = {11'h000, cpu_wdata_in[`SEG_BASE_W-1:0]};
        `REG_TX_FIFO_BASE: s_d.tx_fifo  = {4'h0, cpu_wdata_in[`FIFO_BASE_W-1:0]};
        `REG_REASSEMBLY_CONTROL_BASE:  s_d.reassembly_control   = {13'h0000, cpu_wdata_in[`REASSEMBLY_CONTROL_BASE_W-1:0]};
        `REG_RX_FIFO_BASE: s_d.rx_fifo  = {4'h0, cpu_wdata_in[`FIFO_BASE_W-1:0]};
        default:           s_d.rdata    = s_q.rdata;
      endcase
    end
    if (cpu_rd_in) begin
      unique case (cpu_addr_in)
        `REG_SEG_BASE:     s_d.rdata = s_q.seg_base;
        `REG_TX_FIFO_BASE: s_d.rdata = s_q.tx_fifo;
        `REG_REASSEMBLY_CONTROL_BASE:  s_d.rdata = s_q.reassembly_control;
        `REG_RX_FIFO_BASE: s_d.rdata = s_q.rx_fifo;
        default:           s_d.rdata = 16'h0000;
      endcase
    end
    // address former, one cycle from request
    if (form_valid_in) begin
      s_d.form_vld = 1'b1;
      unique case (form_in.kind)
        FORM_RX_BUF: s_d.form_addr = rxbuf_addr;
        FORM_REASSEMBLY_CONTROL: s_d.form_addr = {s_q.reassembly_control[2:0], form_in.ptr[17:8],
                                      8'({form_in.ptr[7:4], 4'h0} + form_in.offset[7:0])};
        FORM_TX_FIFO: s_d.form_addr = {s_q.tx_fifo[11:0], 9'h000} |
                                      {8'h00, form_in.offset};
        FORM_RX_FIFO: s_d.form_addr = {s_q.rx_fifo[11:0], 9'h000} |
                                      {8'h00, form_in.offset};
        // four bytes per entry, index in offset
        FORM_MEMCTL: s_d.form_addr = {form_in.ptr[20:9], 9'h000} |
                                     {8'h00, form_in.offset[10:0], 2'b00};
        default:     s_d.form_addr = 21'h000000;
      endcase
    end
    // transmit access sequencer
    unique case (s_q.st)
      SEQ_IDLE: begin
        if (job_take) begin
          s_d.kind   = job_in.kind;
          s_d.base   = job_in.base;
          s_d.off    = 8'h00;
          s_d.post_n = 5'h00;
          s_d.st     = SEQ_PRE;
          unique case (job_in.kind)
            JOB_CELL: begin
              s_d.base   = {s_q.seg_base[4:0], job_in.base[15:4], 4'h0};
              s_d.left   = `CELL_CTRL_READS;
              s_d.post_n = (job_in.count > `CELL_MAX_SELECTS) ? `CELL_MAX_SELECTS
                                                               : job_in.count;
            end
            JOB_SCHED:   s_d.left = `SCHED_FRAME_READS;
            JOB_CB_CTRL: s_d.left = `CB_CTRL_READS;
            JOB_CB_DATA: begin
              s_d.st     = SEQ_WR;
              s_d.left   = 5'h01;
              s_d.post_n = `CB_HALF_READS;
            end
          endcase
        end
      end
      SEQ_PRE: begin
        if (mem_ack_in) begin
          s_d.left = s_q.left - 5'h01;
          s_d.off  = s_q.off + `WORD_STRIDE;
          if (s_q.left == 5'h01) begin
            // control update follows the three reads
            if (s_q.kind == JOB_CELL) begin
              s_d.st  = SEQ_WR;
              s_d.off = 8'h00;
            end else begin
              s_d.st = SEQ_IDLE;
            end
          end
        end
      end
      SEQ_WR: begin
        if (mem_ack_in) begin
          s_d.left = s_q.post_n;
          s_d.off  = (s_q.kind == JOB_CELL) ? `CELL_SELECT_OFFSET : 8'h00;
          s_d.st   = (s_q.post_n == 5'h00) ? SEQ_IDLE : SEQ_POST;
        end
      end
      SEQ_POST: begin
        if (mem_ack_in) begin
          s_d.left = s_q.left - 5'h01;
          s_d.off  = s_q.off + ((s_q.kind == JOB_CB_DATA) ? `BYTE_STRIDE : `WORD_STRIDE);
          if (s_q.left == 5'h01) begin
            s_d.st = SEQ_IDLE;
          end
        end
      end
    endcase
    s_d.acc = make_acc(s_d);
  end

  // memory, logic and processor share one clock
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      s_q          <= '0;
      s_q.st       <= SEQ_IDLE;
      s_q.seg_base <= `REG_RESET;
      s_q.tx_fifo  <= `REG_RESET;
      s_q.reassembly_control   <= `REG_RESET;
      s_q.rx_fifo  <= `REG_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // checks

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  sequence s_cell_take;
    job_take && job_in.kind == JOB_CELL;
  endsequence
  sequence s_three_reads;
    (mem_req_out && !mem_acc_out.we && mem_ack_in) [*3];
  endsequence

  property p_cell_first;
    s_cell_take |=> mem_req_out && !mem_acc_out.we &&
      mem_acc_out.addr == {$past(s_q.seg_base[4:0]), $past(job_in.base[15:4]), 4'h0};
  endproperty
  a_cell_first: assert property (p_cell_first) else $error("cell read address wrong");

  property p_cell_write;
    s_cell_take ##1 s_three_reads |=> mem_acc_out.we && mem_acc_out.addr[3:0] == 4'h0;
  endproperty
  a_cell_write: assert property (p_cell_write) else $error("no write after three reads");

  property p_sched_reads;
    job_take && job_in.kind == JOB_SCHED |=> s_q.left == 5'h08 && !mem_acc_out.we;
  endproperty
  a_sched_reads: assert property (p_sched_reads) else $error("scheduler burst wrong");

  property p_cbctrl_one;
    job_take && job_in.kind == JOB_CB_CTRL ##1 mem_ack_in |=> !mem_req_out;
  endproperty
  a_cbctrl_one: assert property (p_cbctrl_one) else $error("extra control read");

  sequence s_cbdata_take;
    job_take && job_in.kind == JOB_CB_DATA;
  endsequence
  property p_cbdata_half;
    s_cbdata_take |=> mem_req_out && mem_acc_out.we && !mem_acc_out.half &&
      mem_acc_out.addr == $past(job_in.base);
  endproperty
  a_cbdata_half: assert property (p_cbdata_half) else $error("data write missing");

  property p_half_reads;
    s_q.kind == JOB_CB_DATA && mem_req_out && mem_acc_out.we && mem_ack_in |=>
      mem_req_out && mem_acc_out.half && !mem_acc_out.we &&
      mem_acc_out.addr == $past(mem_acc_out.addr);
  endproperty
  a_half_reads: assert property (p_half_reads) else $error("half read flag wrong");

  property p_rxsar;
    form_valid_in && form_in.kind == FORM_REASSEMBLY_CONTROL |=> form_valid_out &&
      form_addr_out[20:18] == $past(s_q.reassembly_control[2:0]) &&
      form_addr_out[17:8] == $past(form_in.ptr[17:8]);
  endproperty
  a_rxsar: assert property (p_rxsar) else $error("reassembly address wrong");

  property p_rxbuf;
    form_valid_in && form_in.kind == FORM_RX_BUF |=>
      form_addr_out[20:10] == $past(form_in.ptr[20:10]) &&
      form_addr_out[5:0] == $past(form_in.offset[5:0]);
  endproperty
  a_rxbuf: assert property (p_rxbuf) else $error("receive buffer address wrong");

  property p_rxfifo;
    form_valid_in && form_in.kind == FORM_RX_FIFO && form_in.offset[12:9] == 4'h0 |=>
      form_addr_out[20:9] == $past(s_q.rx_fifo[11:0]);
  endproperty
  a_rxfifo: assert property (p_rxfifo) else $error("receive fifo base wrong");

  property p_txfifo;
    form_valid_in && form_in.kind == FORM_TX_FIFO && form_in.offset[12:9] == 4'h0 |=>
      form_addr_out[20:9] == $past(s_q.tx_fifo[11:0]) &&
      form_addr_out[5:0] == $past(form_in.offset[5:0]);
  endproperty
  a_txfifo: assert property (p_txfifo) else $error("transmit fifo slot wrong");

  property p_memctl;
    form_valid_in && form_in.kind == FORM_MEMCTL |=> form_addr_out[1:0] == 2'b00 &&
      form_addr_out[8:2] == $past(form_in.offset[6:0]) &&
      form_addr_out[20:13] == $past(form_in.ptr[20:13]);
  endproperty
  a_memctl: assert property (p_memctl) else $error("entry not word aligned");
endmodule
`default_nettype wire

/* test/sram_model.sv */
// synchronous sram seen by the access sequencer: acks at once or after random waits
// assumes one request at a time, descriptor held by the design until acked
`default_nettype none
module sram_model (
  input  wire logic sys_clk_in,
  input  wire logic rst_in,
  input  wire logic slow_in,
  input  wire logic mem_req_in,
  output logic      mem_ack_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic go_q;
  always @(posedge sys_clk_in) begin
    go_q <= rst_in ? 1'b0 : (!slow_in || ($urandom_range(1) != 0));
  end
  // ack only qualifies a pending request, never stands alone
  assign mem_ack_out = mem_req_in && go_q;
endmodule
`default_nettype wire

/* test/sar_external_memory_layout_test.sv */
// self-checking bench for the address former, register port and access sequencer
// assumes the sram model beside it; expectations queued by drivers, popped by a watcher
`include "sar_mem_cfg.svh"
`default_nettype none
module sar_external_memory_layout_test;
  timeunit 1ns;
  timeprecision 1ps;
  import sar_mem_pkg::*;
  localparam logic [15:0] RA [4] = '{`REG_SEG_BASE, `REG_TX_FIFO_BASE, `REG_REASSEMBLY_CONTROL_BASE,
                                     `REG_RX_FIFO_BASE};
  localparam logic [15:0] MSK [4] = '{16'h001F, 16'h0FFF, 16'h0007, 16'h0FFF};
  localparam logic [4:0]  CNT [4] = '{5'h00, 5'h01, 5'h18, 5'h1F};
  logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, jv = 1'b0, fv = 1'b0;
  logic        slow = 1'b0, rd_p = 1'b0, jrdy, req, ack, fvo;
  logic [15:0] addr = 16'h0000, wdata = 16'h0000, rdata;
  logic [15:0] v [4];
  job_t        job = '0;
  form_req_t   form = '0;
  mem_acc_t    acc;
  logic [20:0] faddr;
  logic [15:0] rq [$];
  logic [20:0] fq [$];
  mem_acc_t    mq [$];
  int          num_errors = 0;
  int          check_count = 0;
  always #2 clk = ~clk;
  sar_external_memory_layout dut (.sys_clk_in(clk), .rst_in(rst), .cpu_addr_in(addr),
    .cpu_wdata_in(wdata), .cpu_wr_in(wr), .cpu_rd_in(rd), .cpu_rdata_out(rdata),
    .job_valid_in(jv), .job_in(job), .job_ready_out(jrdy), .mem_req_out(req),
    .mem_acc_out(acc), .mem_ack_in(ack), .form_valid_in(fv), .form_in(form),
    .form_valid_out(fvo), .form_addr_out(faddr));
  sram_model mem (.sys_clk_in(clk), .rst_in(rst), .slow_in(slow), .mem_req_in(req),
    .mem_ack_out(ack));
  task automatic chk(input logic [22:0] got, input logic [22:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // a result with no note queued compares against unknown and so fails
  always @(posedge clk) begin
    rd_p <= rd && !rst;
    if (rd_p) chk({7'h00, rdata}, rq.size() ? rq.pop_front() : 'x, "read data");
    if (fvo) chk({2'b00, faddr}, fq.size() ? fq.pop_front() : 'x, "formed address");
    if (req && ack) chk(acc, mq.size() ? mq.pop_front() : 'x, "memory access");
  end
  task automatic wait_idle;
    int n;
    n = 0;
    while ((mq.size() || fq.size() || rq.size() || jrdy !== 1'b1) && n < 2000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 2000) begin
      num_errors++;
      $display("Error at %0t: wait for idle ran out", $time);
      end_sim();
    end
    @(posedge clk);
  endtask
  task automatic reg_wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [15:0] a, input logic [15:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    rq.push_back(e);
    @(posedge clk);
    rd <= 1'b0;
  endtask
  // valid stays up so successive calls are back to back
  task automatic form_go(input form_kind_t k, input logic [20:0] p, input logic [2:0] sc,
                         input logic [12:0] o, input logic [20:0] e);
    @(posedge clk);
    fv <= 1'b1;
    form <= '{k, p, sc, o};
    fq.push_back(e);
  endtask
  task automatic acc_note(input logic [20:0] b, input int off, input logic we, input logic hf);
    logic [7:0] lo;
    lo = b[7:0] + off[7:0];
    mq.push_back('{{b[20:8], lo}, we, hf});
  endtask
  // caller waits for idle before queueing notes, else the wait never drains
  task automatic job_go(input job_kind_t k, input logic [20:0] b, input logic [4:0] c);
    jv <= 1'b1;
    job <= '{k, b, c};
    @(posedge clk);
    jv <= 1'b0;
  endtask
  initial begin
    logic [20:0] p, b, m;
    logic [12:0] o;
    logic [7:0]  t;
    logic [31:0] w;
    void'($urandom(32'hd6a597ed));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    foreach (RA[i]) reg_rd(RA[i], 16'h0000);
    foreach (RA[i]) begin
      w = $urandom();
      reg_wr(RA[i], w[15:0]);
      v[i] = w[15:0] & MSK[i];
    end
    foreach (RA[i]) reg_rd(RA[i], v[i]);
    reg_wr(16'h2042, 16'hFFFF);
    reg_rd(16'h2042, 16'h0000);
    $display("register test done");
    for (int s = 0; s < 6; s++) begin
      p = $urandom();
      o = $urandom();
      m = (21'h1 << (6 + (s > 4 ? 4 : s))) - 21'h1;
      form_go(FORM_RX_BUF, p, s[2:0], o, (p & ~m) | ({8'h00, o} & m));
    end
    repeat (3) begin
      p = $urandom();
      o = $urandom();
      t = {p[7:4], 4'h0} + o[7:0];
      form_go(FORM_REASSEMBLY_CONTROL, p, 3'h0, o, {v[2][2:0], p[17:8], t});
      form_go(FORM_MEMCTL, p, 3'h0, o, {p[20:9], 9'h000} | {8'h00, o[10:0], 2'b00});
      // cell slot and byte within it
      o = 13'(($urandom_range(127) << 6) | $urandom_range(63));
      form_go(FORM_TX_FIFO, p, 3'h0, o, {v[1][11:0], 9'h000} | {8'h00, o});
      form_go(FORM_RX_FIFO, p, 3'h0, o, {v[3][11:0], 9'h000} | {8'h00, o});
    end
    // offset inside the first 512 bytes so the base bits stand alone
    o = 13'($urandom_range(511));
    form_go(FORM_TX_FIFO, p, 3'h0, o, {v[1][11:0], 9'h000} | {8'h00, o});
    form_go(FORM_RX_FIFO, p, 3'h0, o, {v[3][11:0], 9'h000} | {8'h00, o});
    @(posedge clk);
    fv <= 1'b0;
    wait_idle();
    $display("address former test done");
    foreach (CNT[i]) begin
      wait_idle();
      b = $urandom();
      slow <= i[0];
      p = {v[0][4:0], b[15:4], 4'h0};
      for (int k = 0; k < 3; k++) acc_note(p, 4 * k, 1'b0, 1'b0);
      acc_note(p, 0, 1'b1, 1'b0);
      for (int k = 0; k < (CNT[i] > 24 ? 24 : CNT[i]); k++) acc_note(p, 12 + 4 * k, 1'b0, 1'b0);
      job_go(JOB_CELL, b, CNT[i]);
    end
    b = $urandom();
    wait_idle();
    for (int k = 0; k < 8; k++) acc_note(b, 4 * k, 1'b0, 1'b0);
    job_go(JOB_SCHED, b, 5'h00);
    wait_idle();
    acc_note(b, 0, 1'b0, 1'b0);
    job_go(JOB_CB_CTRL, b, 5'h00);
    // write then half reads, with prompt and with stalling memory
    for (int j = 0; j < 2; j++) begin
      wait_idle();
      slow <= j[0];
      acc_note(b, 0, 1'b1, 1'b0);
      for (int k = 0; k < 4; k++) acc_note(b, k, 1'b0, 1'b1);
      job_go(JOB_CB_DATA, b, 5'h00);
    end
    wait_idle();
    $display("sequencer test done");
    end_sim();
  end
endmodule
`default_nettype wire
